// ### stf_map.vh
// Constants of the section tunnel framer: prefix layout, fixed field
// values, header sizes and size limits.
// Assumes it is included by its bare name from each design file that uses its constants.
`ifndef STF_MAP_VH
`define STF_MAP_VH

// Tunnel prefix fields.
`define STF_SYNC_MARKER 8'hFF
`define STF_TUN_VERSION 3'h1
`define STF_TUN_PFX_LEN 16'h0004

// Carousel prefix fields.
`define STF_CAR_VERSION 2'h1
`define STF_CAR_RSVD 1'h1
`define STF_CAR_PFX_LEN 16'h0002

// Header sizes in bytes that sit in front of the prefix.
`define STF_IP_HDR_LEN 16'h0014
`define STF_UDP_HDR_LEN 16'h0008

// Largest packed section in bytes.
`define STF_MAX_SECTION 13'h1000

// Piece index width and the most pieces one section may use.
`define STF_IDX_W 4
`define STF_MAX_PIECES 5'h10

// Reset value of the section tag counter.
`define STF_TAG_RESET 16'h0000

`endif

// ### stf_buf2.v
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on clk; a stall downstream fills the spare entry
// and then drops in_ready, so no word is ever lost.
`timescale 1ns/1ns
module stf_buf2 #(
    parameter W = 10
) (
    input wire clk,
    input wire rstn,
    input wire in_valid,
    output reg in_ready,
    input wire [W-1:0] in_data,
    output reg out_valid,
    input wire out_ready,
    output reg [W-1:0] out_data
);

    reg [W-1:0] spare;

    // ****************************************************************
    // Holding and spare entry
    // ****************************************************************
    always @(posedge clk) begin
        if (!rstn) begin
            in_ready <= 1'b1;
            out_valid <= 1'b0;
            out_data <= {W{1'b0}};
            spare <= {W{1'b0}};
        end else if (in_ready) begin
            if (!out_valid || out_ready) begin
                out_valid <= in_valid;
                out_data <= in_data;
            end else if (in_valid) begin
                spare <= in_data;
                in_ready <= 1'b0;
            end
        end else if (out_ready) begin
            out_data <= spare;
            out_valid <= 1'b1;
            in_ready <= 1'b1;
        end
    end

endmodule // stf_buf2

// ### stf_prefix.v
// Prefix byte selector for tunnel and carousel datagrams.
// Assumes the caller steps byte_sel from zero and stops at the last byte
// of the chosen prefix; purely combinational.
`timescale 1ns/1ns
`include "stf_map.vh"
module stf_prefix (
    input wire carousel,
    input wire final_piece,
    input wire [3:0] piece_index,
    input wire [15:0] section_tag,
    input wire [12:0] transport_pid_field,
    input wire [1:0] byte_sel,
    output reg [7:0] pfx_byte
);

    always @* begin
        pfx_byte = 8'h00;
        if (carousel) begin
            if (byte_sel == 2'h0) begin
                pfx_byte = {`STF_CAR_VERSION, `STF_CAR_RSVD,
                            transport_pid_field[12:8]};
            end else begin
                pfx_byte = transport_pid_field[7:0];
            end
        end else begin
            case (byte_sel)
                2'h0: pfx_byte = `STF_SYNC_MARKER;
                2'h1: pfx_byte = {`STF_TUN_VERSION, final_piece,
                                  piece_index};
                2'h2: pfx_byte = section_tag[15:8];
                default: pfx_byte = section_tag[7:0];
            endcase
        end
    end

endmodule // stf_prefix

// ### stf_framer.v
// Section tunnel framer: turns a byte stream of table sections into UDP
// payloads carrying a tunnel prefix or a carousel prefix.
// Assumes the upstream source gives the section length, mode and PID with
// the first byte, and that the IP/UDP headers are added further on.
`timescale 1ns/1ns
`include "stf_map.vh"
module stf_framer (
    input wire clk,
    input wire rstn,
    input wire [15:0] mtu_bytes,
    input wire sec_valid,
    output wire sec_ready,
    input wire [7:0] sec_data,
    input wire sec_last,
    input wire [12:0] sec_len,
    input wire sec_carousel,
    input wire [12:0] sec_pid,
    output wire dg_valid,
    input wire dg_ready,
    output wire [7:0] dg_data,
    output wire dg_first,
    output wire dg_last,
    output reg drop_oversize,
    output reg drop_nofit,
    output reg busy
);

    // ****************************************************************
    // States
    // ****************************************************************
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_PFX = 4'h2;
    localparam [3:0] ST_BODY = 4'h4;
    localparam [3:0] ST_DROP = 4'h8;

    reg [3:0] state;
    reg carousel;
    reg [12:0] pid;
    reg [15:0] section_tag;
    reg [3:0] piece_index;
    reg [12:0] seg_size;
    reg [12:0] remaining;
    reg [12:0] seg_cnt;
    reg [1:0] pfx_cnt;

    // ****************************************************************
    // Room checks made on the first byte of a section
    // ****************************************************************
    wire [15:0] ip_udp_len;
    wire [15:0] udp_room;
    wire [15:0] tun_room;
    wire [16:0] tun_limit;
    wire [15:0] car_need;
    wire [12:0] tun_seg;
    wire too_big;
    wire no_fit;

    assign ip_udp_len = `STF_IP_HDR_LEN + `STF_UDP_HDR_LEN;
    assign udp_room = (mtu_bytes > ip_udp_len) ?
                      (mtu_bytes - ip_udp_len) : 16'h0000;
    // Payload room of one tunnel segment after its four prefix bytes.
    assign tun_room = (udp_room > `STF_TUN_PFX_LEN) ?
                      (udp_room - `STF_TUN_PFX_LEN) : 16'h0000;
    // Every segment but the last is cut at the largest fitting size.
    assign tun_seg = (tun_room > {3'h0, `STF_MAX_SECTION}) ?
                     `STF_MAX_SECTION : tun_room[12:0];
    assign tun_limit = {1'b0, tun_room} * {12'h000, `STF_MAX_PIECES};
    assign car_need = {3'h0, sec_len} + `STF_CAR_PFX_LEN;
    assign too_big = (sec_len > `STF_MAX_SECTION) ||
                     (sec_len == 13'h0000);
    assign no_fit = sec_carousel ? (car_need > udp_room)
                  : ((tun_room == 16'h0000) ||
                     ({4'h0, sec_len} > tun_limit));

    // ****************************************************************
    // Prefix bytes and the word pushed into the buffer
    // ****************************************************************
    wire final_piece;
    wire [7:0] pfx_byte;
    wire [1:0] pfx_end;
    wire seg_end;
    wire buf_ready;
    reg push_valid;
    reg [9:0] push_word;

    // The final flag is known up front since the byte count is known.
    assign final_piece = (remaining <= seg_size);
    assign pfx_end = carousel ? 2'h1 : 2'h3;
    assign seg_end = (seg_cnt + 13'h0001 == seg_size) ||
                     (remaining == 13'h0001) || sec_last;

    stf_prefix u_prefix (
        .carousel(carousel),
        .final_piece(final_piece),
        .piece_index(piece_index),
        .section_tag(section_tag),
        .transport_pid_field(pid),
        .byte_sel(pfx_cnt),
        .pfx_byte(pfx_byte)
    );

    always @* begin
        push_valid = 1'b0;
        push_word = 10'h000;
        case (state)
            ST_PFX: begin
                push_valid = 1'b1;
                // The prefix opens every datagram, before section bytes.
                push_word = {(pfx_cnt == 2'h0), 1'b0, pfx_byte};
            end
            ST_BODY: begin
                push_valid = sec_valid;
                push_word = {1'b0, seg_end, sec_data};
            end
            default: begin
                push_valid = 1'b0;
                push_word = 10'h000;
            end
        endcase
    end

    // Section bytes are taken only while the buffer has room; a dropped
    // section is drained at full rate.
    assign sec_ready = ((state == ST_BODY) && buf_ready) ||
                       (state == ST_DROP);

    wire body_take;
    wire pfx_take;
    assign body_take = (state == ST_BODY) && sec_valid && buf_ready;
    assign pfx_take = (state == ST_PFX) && buf_ready;

    // ****************************************************************
    // Framing state machine
    // ****************************************************************
    always @(posedge clk) begin
        if (!rstn) begin
            state <= ST_IDLE;
            carousel <= 1'b0;
            pid <= 13'h0000;
            section_tag <= `STF_TAG_RESET;
            piece_index <= 4'h0;
            seg_size <= 13'h0000;
            remaining <= 13'h0000;
            seg_cnt <= 13'h0000;
            pfx_cnt <= 2'h0;
            drop_oversize <= 1'b0;
            drop_nofit <= 1'b0;
            busy <= 1'b0;
        end else begin
            drop_oversize <= 1'b0;
            drop_nofit <= 1'b0;
            case (state)
                ST_IDLE: begin
                    busy <= 1'b0;
                    if (sec_valid) begin
                        busy <= 1'b1;
                        carousel <= sec_carousel;
                        pid <= sec_pid;
                        remaining <= sec_len;
                        piece_index <= 4'h0;
                        pfx_cnt <= 2'h0;
                        seg_cnt <= 13'h0000;
                        // Whole section in one datagram when it fits.
                        if (sec_carousel || ({3'h0, sec_len} <= tun_room)) begin
                            seg_size <= sec_len;
                        end else begin
                            seg_size <= tun_seg;
                        end
                        if (too_big) begin
                            drop_oversize <= 1'b1;
                            state <= ST_DROP;
                        end else if (no_fit) begin
                            drop_nofit <= 1'b1;
                            state <= ST_DROP;
                        end else begin
                            state <= ST_PFX;
                        end
                    end
                end
                ST_PFX: begin
                    if (pfx_take) begin
                        pfx_cnt <= pfx_cnt + 2'h1;
                        if (pfx_cnt == pfx_end) begin
                            pfx_cnt <= 2'h0;
                            seg_cnt <= 13'h0000;
                            state <= ST_BODY;
                        end
                    end
                end
                ST_BODY: begin
                    if (body_take) begin
                        remaining <= remaining - 13'h0001;
                        seg_cnt <= seg_cnt + 13'h0001;
                        if ((remaining == 13'h0001) || sec_last) begin
                            // The next section waits until this one ends.
                            if (!carousel) begin
                                section_tag <= section_tag + 16'h0001;
                            end
                            state <= ST_IDLE;
                        end else if (seg_end) begin
                            piece_index <= piece_index + 4'h1;
                            state <= ST_PFX;
                        end
                    end
                end
                ST_DROP: begin
                    if (sec_valid && sec_last) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Output buffer
    // ****************************************************************
    wire [9:0] dg_word;

    stf_buf2 #(
        .W(10)
    ) u_buf (
        .clk(clk),
        .rstn(rstn),
        .in_valid(push_valid),
        .in_ready(buf_ready),
        .in_data(push_word),
        .out_valid(dg_valid),
        .out_ready(dg_ready),
        .out_data(dg_word)
    );

    assign dg_first = dg_word[9];
    assign dg_last = dg_word[8];
    assign dg_data = dg_word[7:0];

endmodule // stf_framer

// ### stf_monitor.sv
// Checker for the framer output stream.
// Assumes it is bound to stf_framer and sees only its ports.
`timescale 1ns/1ns
module stf_monitor (
    input wire clk,
    input wire rstn,
    input wire [15:0] mtu_bytes,
    input wire sec_valid,
    input wire sec_carousel,
    input wire busy,
    input wire dg_valid,
    input wire dg_ready,
    input wire [7:0] dg_data,
    input wire dg_first,
    input wire dg_last
);
    // *********
    // Checks
    // *********
    reg [12:0] pos;
    reg [3:0] idx;
    reg car;
    wire take = dg_valid && dg_ready;
    // Byte position in the datagram and the expected piece index.
    always @(posedge clk) begin
        if (!rstn) begin
            pos <= 13'h0000;
            idx <= 4'h0;
            car <= 1'b0;
        end else begin
            if (!busy && sec_valid)
                car <= sec_carousel;
            if (take)
                pos <= dg_last ? 13'h0000 : pos + 13'h0001;
            if (take && !car && pos == 13'h0001)
                idx <= dg_data[4] ? 4'h0 : dg_data[3:0] + 4'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_tun_head; dg_valid && pos == 13'h0000 && !car; endsequence
    sequence s_car_head; dg_valid && pos == 13'h0000 && car; endsequence
    sequence s_ctl; dg_valid && pos == 13'h0001 && !car; endsequence
    sequence s_stall; dg_valid && !dg_ready; endsequence
    property p_sync; s_tun_head |-> dg_data == 8'hFF; endproperty
    property p_ver; s_ctl |-> dg_data[7:5] == 3'h1; endproperty
    property p_idx; s_ctl |-> dg_data[3:0] == idx; endproperty
    property p_car; s_car_head |-> dg_data[7:5] == 3'h3; endproperty
    property p_first; dg_valid |-> dg_first == (pos == 13'h0000); endproperty
    property p_fit; dg_valid |-> {3'h0, pos} + 16'h001D <= mtu_bytes;
    endproperty
    property p_max; dg_valid |-> pos < 13'h1004; endproperty
    property p_hold; s_stall |=> dg_valid && $stable(dg_data)
        && $stable(dg_last); endproperty
    a_sync: assert property (p_sync) else $error("bad sync byte");
    a_ver: assert property (p_ver) else $error("bad version");
    a_idx: assert property (p_idx) else $error("bad index");
    a_car: assert property (p_car) else $error("bad carousel");
    a_first: assert property (p_first) else $error("bad first");
    a_fit: assert property (p_fit) else $error("over mtu");
    a_max: assert property (p_max) else $error("too long");
    a_hold: assert property (p_hold) else $error("word lost");
endmodule // stf_monitor
bind stf_framer stf_monitor u_stf_monitor (.clk(clk), .rstn(rstn),
    .mtu_bytes(mtu_bytes), .sec_valid(sec_valid), .busy(busy),
    .sec_carousel(sec_carousel), .dg_valid(dg_valid),
    .dg_ready(dg_ready), .dg_data(dg_data), .dg_first(dg_first),
    .dg_last(dg_last));

// ### stf_sink.sv
// Downstream receiver model for the framer output stream.
// Assumes one clock; slow gives a ready that is low three cycles of four.
`timescale 1ns/1ns
module stf_sink (
    input wire clk,
    input wire rstn,
    input wire slow,
    input wire dg_valid,
    input wire [7:0] dg_data,
    input wire dg_first,
    input wire dg_last,
    output reg dg_ready,
    output integer n_dg,
    output integer n_sec,
    output integer n_bad
);
    // *********
    // Model
    // *********
    logic [7:0] bq [$];
    reg [1:0] ph;
    reg fin;
    reg two;
    // Prefix byte position, tag tracking and carousel PID selection.
    localparam [12:0] WANT_PID = 13'h0ABC;
    reg [2:0] hp;
    reg tun;
    reg mid;
    reg [7:0] th;
    reg [15:0] cur_tag;
    integer n_pid;
    initial begin
        n_pid = 0;
        n_dg = 0;
        n_sec = 0;
        n_bad = 0;
    end
    always @(posedge clk) begin
        ph <= rstn ? ph + 2'h1 : 2'h0;
        dg_ready <= rstn && (!slow || ph == 2'h3);
        if (!rstn) begin
            hp <= 3'h0;
            mid <= 1'b0;
            tun <= 1'b0;
        end
        if (rstn && dg_valid && dg_ready) begin
            bq.push_back(dg_data);
            hp <= dg_last ? 3'h0 : ((hp == 3'h7) ? hp : hp + 3'h1);
            if (dg_first) begin
                tun <= dg_data == 8'hFF;
                th <= dg_data;
            end
            if (hp == 3'h2 && tun)
                th <= dg_data;
            if (hp == 3'h3 && tun) begin
                if (mid && {th, dg_data} != cur_tag)
                    n_bad <= n_bad + 1;
                cur_tag <= {th, dg_data};
                mid <= !fin;
            end
            if (hp == 3'h1 && !tun && {th[4:0], dg_data} == WANT_PID)
                n_pid <= n_pid + 1;
            if (dg_first && dg_data != 8'hFF && dg_data[7:5] != 3'h3)
                n_bad <= n_bad + 1;
            two <= dg_first && dg_data == 8'hFF;
            if (dg_first)
                fin <= dg_data[7:5] == 3'h3;
            if (two)
                fin <= dg_data[4];
            if (dg_last)
                n_dg <= n_dg + 1;
            if (dg_last && fin)
                n_sec <= n_sec + 1;
        end
    end
endmodule // stf_sink

// ### stf_framer_tb.sv
// Self-checking bench for the section tunnel framer.
// Assumes stf_framer, stf_sink and the bound checker are compiled first.
`timescale 1ns/1ns
module stf_framer_tb;
    // *********
    // Bench
    // *********
    typedef struct packed {
        logic [12:0] len;
        logic car;
        logic slw;
        logic [15:0] mtu;
        logic [4:0] dg;
        logic [1:0] drop;
    } stf_row_t;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg sec_valid = 1'b0;
    reg sec_last = 1'b0;
    reg sec_carousel = 1'b0;
    reg slow = 1'b0;
    reg [7:0] sec_data = 8'h00;
    reg [12:0] sec_len = 13'h0000;
    reg [15:0] mtu_bytes = 16'h05DC;
    reg [15:0] tag = 16'h0000;
    wire sec_ready, dg_valid, dg_ready, dg_first, dg_last;
    wire drop_oversize, drop_nofit, busy;
    wire [7:0] dg_data;
    wire [12:0] sec_pid = 13'h0ABC;
    integer error_cnt = 0, n_tests = 0, cyc = 0, n_ov = 0, n_nf = 0, ri;
    logic [7:0] eq [$];
    stf_row_t rows [0:9] = '{
        '{13'h000A, 1'h0, 1'h0, 16'h05DC, 5'h01, 2'h0},
        '{13'h0064, 1'h0, 1'h1, 16'h0052, 5'h02, 2'h0},
        '{13'h0065, 1'h0, 1'h0, 16'h0052, 5'h03, 2'h0},
        '{13'h0014, 1'h1, 1'h1, 16'h05DC, 5'h01, 2'h0},
        '{13'h0034, 1'h1, 1'h0, 16'h0052, 5'h01, 2'h0},
        '{13'h0035, 1'h1, 1'h0, 16'h0052, 5'h00, 2'h2},
        '{13'h0010, 1'h0, 1'h0, 16'h0021, 5'h10, 2'h0},
        '{13'h0011, 1'h0, 1'h0, 16'h0021, 5'h00, 2'h2},
        '{13'h1000, 1'h0, 1'h0, 16'h05DC, 5'h03, 2'h0},
        '{13'h1001, 1'h0, 1'h0, 16'h05DC, 5'h00, 2'h1}};
    stf_framer u_stf_framer (.clk(clk), .rstn(rstn), .mtu_bytes(mtu_bytes),
        .sec_valid(sec_valid), .sec_ready(sec_ready), .sec_data(sec_data),
        .sec_last(sec_last), .sec_len(sec_len), .sec_pid(sec_pid),
        .sec_carousel(sec_carousel), .dg_valid(dg_valid),
        .dg_ready(dg_ready), .dg_data(dg_data), .dg_first(dg_first),
        .dg_last(dg_last), .drop_oversize(drop_oversize),
        .drop_nofit(drop_nofit), .busy(busy));
    stf_sink u_stf_sink (.clk(clk), .rstn(rstn), .slow(slow),
        .dg_valid(dg_valid), .dg_data(dg_data), .dg_first(dg_first),
        .dg_last(dg_last), .dg_ready(dg_ready), .n_dg(), .n_sec(),
        .n_bad());
    always #25 clk = ~clk;
    always @(posedge clk) begin
        n_ov <= n_ov + drop_oversize;
        n_nf <= n_nf + drop_nofit;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt = error_cnt + 1;
            report_and_stop;
        end
    end
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests = n_tests + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Expected stream: prefix, then payload bytes equal to their offset.
    task automatic build(input stf_row_t r);
        int p, n, i, j, k;
        k = 0;
        if (r.car) begin
            eq.push_back({3'h3, sec_pid[12:8]});
            eq.push_back(sec_pid[7:0]);
            for (i = 0; i < r.len; i++)
                eq.push_back(i[7:0]);
        end else begin
            p = (r.mtu - 32 > 4096) ? 4096 : r.mtu - 32;
            n = (r.len + p - 1) / p;
            for (i = 0; i < n; i++) begin
                eq.push_back(8'hFF);
                eq.push_back({3'h1, i == n - 1, i[3:0]});
                eq.push_back(tag[15:8]);
                eq.push_back(tag[7:0]);
                for (j = 0; j < ((i == n - 1) ? r.len - k : p); j++)
                    eq.push_back(k[7:0] + j[7:0]);
                k = k + p;
            end
            tag = tag + 16'h0001;
        end
    endtask
    task automatic send(input stf_row_t r, input int nb);
        int i, w;
        for (i = 0; i < nb; i++) begin
            @(negedge clk);
            sec_valid = 1'b1;
            sec_data = i[7:0];
            sec_last = (i == r.len - 1);
            sec_len = r.len;
            sec_carousel = r.car;
            w = 0;
            while (sec_ready !== 1'b1 && w < 200) begin
                @(negedge clk);
                w = w + 1;
            end
            @(posedge clk);
        end
        @(negedge clk);
        sec_valid = 1'b0;
    endtask
    task automatic run(input stf_row_t r);
        int b0, b1, b2, b3, i, w;
        mtu_bytes = r.mtu;
        slow = r.slw;
        b0 = u_stf_sink.n_dg;
        b1 = n_ov;
        b2 = n_nf;
        b3 = u_stf_sink.n_sec;
        repeat (2) @(negedge clk);
        if (r.drop == 2'h0)
            build(r);
        send(r, r.len);
        w = 0;
        while ((busy !== 1'b0 || dg_valid !== 1'b0) && w < 20000) begin
            @(negedge clk);
            w = w + 1;
        end
        repeat (3) @(negedge clk);
        chk("datagrams", r.dg, u_stf_sink.n_dg - b0);
        chk("sections", r.drop == 2'h0, u_stf_sink.n_sec - b3);
        chk("drops", r.drop, ((n_nf - b2) << 1) | (n_ov - b1));
        chk("stream size", eq.size(), u_stf_sink.bq.size());
        for (i = 0; i < eq.size() && i < u_stf_sink.bq.size(); i++)
            chk("byte", eq[i], u_stf_sink.bq[i]);
        chk("bad headers", 0, u_stf_sink.n_bad);
        eq.delete();
        u_stf_sink.bq.delete();
        $display("test done len %0d mtu %0d", r.len, r.mtu);
    endtask
    initial begin
        repeat (10) @(negedge clk);
        chk("reset valid", 0, dg_valid);
        chk("reset busy", 0, {busy, sec_ready});
        rstn = 1'b1;
        for (ri = 0; ri < 10; ri++)
            run(rows[ri]);
        // Reset in mid-section, then the tag must start again from zero.
        mtu_bytes = rows[2].mtu;
        send(rows[2], 40);
        rstn = 1'b0;
        repeat (10) @(negedge clk);
        chk("mid reset out", 0, {dg_valid, busy, drop_nofit});
        rstn = 1'b1;
        u_stf_sink.bq.delete();
        tag = 16'h0000;
        run(rows[0]);
        chk("pid hits", 2, u_stf_sink.n_pid);
        report_and_stop;
    end
endmodule // stf_framer_tb
